// *** lbp_consts.svh ***
/*
 constants for the led brightness engine: register indices, reset values,
 field positions and timing figures. assumes a 10 MHz pclk.
*/
`ifndef LBP_CONSTS_SVH
`define LBP_CONSTS_SVH

// register indices; byte address is four times the index
`define LBP_IDX_BR_PERIOD   8'h86
`define LBP_IDX_CONFIG      8'h88
`define LBP_IDX_P1_DUTY     8'h90
`define LBP_IDX_P2_DUTY     8'h91
`define LBP_IDX_BR_DUTY     8'h92
`define LBP_IDX_DR_DUTY     8'h93
`define LBP_IDX_DR_RAMP     8'h94
`define LBP_IDX_STATUS      8'h97

`define LBP_RST_BR_PERIOD   8'h5D
`define LBP_RST_CONFIG      8'h04
`define LBP_RST_P1_DUTY     8'hF0
`define LBP_RST_P2_DUTY     8'hF0
`define LBP_RST_BR_DUTY     8'hF0
`define LBP_RST_DR_DUTY     8'hF0
`define LBP_RST_DR_RAMP     8'h00

`define LBP_RAMP_ALERT_BIT  6
`define LBP_CNT2_MSB        5
`define LBP_CNT2_LSB        3
`define LBP_CNT1_MSB        2
`define LBP_CNT1_LSB        0
`define LBP_TOP_MSB         7
`define LBP_TOP_LSB         4
`define LBP_FLOOR_MSB       3
`define LBP_FLOOR_LSB       0
`define LBP_RISE_MSB        5
`define LBP_RISE_LSB        3
`define LBP_FALL_MSB        2
`define LBP_FALL_LSB        0

`define LBP_CLK_NS          100
`define LBP_MS_NS           1000000
`define LBP_PERIOD_STEP_MS  32
`define LBP_RAMP_STEP_MS    250
`define LBP_RAMP_MAX_MS     2000
`define LBP_PWM_STEPS       100
`define LBP_NCH             8

`endif

// *** lbp_pkg.sv ***
/*
 types for the led brightness engine.
 assumes nothing beyond a SystemVerilog compiler.
*/
package lbp_pkg;
   typedef enum logic [1:0] {
      LBP_DIRECT  = 2'b00,
      LBP_PULSE1  = 2'b01,
      LBP_PULSE2  = 2'b10,
      LBP_BREATHE = 2'b11
   } lbp_mode_t;

   typedef enum logic [1:0] {
      LBP_IDLE = 2'b00,
      LBP_RISE = 2'b01,
      LBP_FALL = 2'b10,
      LBP_TOP  = 2'b11
   } lbp_state_t;

   typedef struct packed {
      lbp_mode_t led_behavior_select;
      logic      actuate;
      logic      by_host;
   } lbp_chan_req_t;
endpackage : lbp_pkg

// *** lbp_led_engine.sv ***
/*
 led brightness engine: apb register file for breathe period, pulse counts,
 duty limits and direct ramp times, eight pwm channels and the alert pulse.
 assumes channel requests and pulse periods come from logic on pclk.
*/
// Behaviour
// [R1] breathe period step is 32 ms
// [R2] breathe period spans 32 ms to 4.064 s
// [R3] breathe period resets to 2976 ms
// [R4] short periods stretch to achievable ramp length
// [R5] alert on host-started behaviour finish when enabled
// [R6] touch-started behaviour never raises alert
// [R7] second pulse count from bits 5:3
// [R8] first pulse count from bits 2:0
// [R9] count code N gives N+1 breaths
// [R10] per-behaviour duty register, top and floor
// [R11] duty ramps floor to top and back
// [R12] direct mode duty changes apply at once
// [R13] other modes latch duty at actuation
// [R14] top code maps to percent table
// [R15] floor code maps to percent table
// [R16] direct rise time from bits 5:3
// [R17] direct fall time from bits 2:0
// [R18] ramp codes select 0 to 2 s
// [R19] breathe ramps each take half period
// [R20] second pulse breathes, finishes count, settles
// [R21] millisecond timebase derived from pclk
// [R22] channels keep independent ramp state
`timescale 1ns/1ps
`include "lbp_consts.svh"

module lbp_led_engine #(
   parameter int unsigned MS_CYCLES = `LBP_MS_NS / `LBP_CLK_NS
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [9:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  lbp_pkg::lbp_chan_req_t     chan_req [`LBP_NCH],
   input  wire logic [6:0]            pulse1_period,
   input  wire logic [6:0]            pulse2_period,
   output logic      [`LBP_NCH-1:0]   led_pwm,
   output logic                       alert_n
);
   import lbp_pkg::*;

   localparam int NCH = `LBP_NCH;

   logic [7:0]  br_period_r, config_r, p1_duty_r, p2_duty_r;
   logic [7:0]  br_duty_r, dr_duty_r, dr_ramp_r;
   logic [7:0]  rd_byte;
   logic        hit;
   logic [13:0] tb_r;
   logic        tick;
   logic [6:0]  pwm_cnt_r;

   lbp_state_t  st_r   [NCH];
   lbp_state_t  st_nxt [NCH];
   lbp_mode_t   m_r    [NCH];
   lbp_mode_t   m_nxt  [NCH];
   logic [6:0]  lvl_r [NCH], lvl_nxt [NCH];
   logic [6:0]  lo_r  [NCH], lo_nxt  [NCH];
   logic [6:0]  hi_r  [NCH], hi_nxt  [NCH];
   logic [11:0] half_r[NCH], half_nxt[NCH];
   logic [11:0] ms_r  [NCH], ms_nxt  [NCH];
   logic [12:0] acc_r [NCH], acc_nxt [NCH];
   logic [2:0]  cnt_r [NCH], cnt_nxt [NCH];
   logic        act_d_r[NCH];
   logic        host_r[NCH], host_nxt[NCH];
   logic        stop_r[NCH], stop_nxt[NCH];
   logic [NCH-1:0] done, done_host;

   function automatic logic [6:0] top_pct(input logic [3:0] c);
      unique case (c)
         4'h0: top_pct = 7'd7;
         4'h1: top_pct = 7'd9;
         4'h2: top_pct = 7'd11;
         4'h3: top_pct = 7'd14;
         4'h4: top_pct = 7'd17;
         4'h5: top_pct = 7'd20;
         4'h6: top_pct = 7'd23;
         4'h7: top_pct = 7'd26;
         4'h8: top_pct = 7'd30;
         4'h9: top_pct = 7'd35;
         4'hA: top_pct = 7'd40;
         4'hB: top_pct = 7'd46;
         4'hC: top_pct = 7'd53;
         4'hD: top_pct = 7'd63;
         4'hE: top_pct = 7'd77;
         4'hF: top_pct = 7'd100;
      endcase
   endfunction : top_pct

   function automatic logic [6:0] floor_pct(input logic [3:0] c);
      floor_pct = (c == 4'h0) ? 7'd0 : top_pct(c - 4'h1); // [R15]
   endfunction : floor_pct

   function automatic logic [11:0] ramp_ms(input logic [2:0] c);
      if (c == 3'h7)
         ramp_ms = 12'(`LBP_RAMP_MAX_MS); // [R18]
      else
         ramp_ms = 12'(c) * 12'(`LBP_RAMP_STEP_MS); // [R18]
   endfunction : ramp_ms

   // half of a period in ms; code zero behaves as code one
   function automatic logic [11:0] half_ms(input logic [6:0] c);
      logic [6:0] k;
      k = (c == 7'h00) ? 7'h01 : c; // [R2]
      half_ms = 12'(k) * 12'(`LBP_PERIOD_STEP_MS / 2); // [R1] [R19]
   endfunction : half_ms

   // apb: zero wait states, unmapped addresses answer with pslverr
   assign pready = 1'b1;

   always_comb begin
      hit = 1'b1;
      rd_byte = 8'h00;
      unique case (paddr[9:2])
         `LBP_IDX_BR_PERIOD: rd_byte = {1'b0, br_period_r[6:0]};
         `LBP_IDX_CONFIG:    rd_byte = {1'b0, config_r[6:0]};
         `LBP_IDX_P1_DUTY:   rd_byte = p1_duty_r;
         `LBP_IDX_P2_DUTY:   rd_byte = p2_duty_r;
         `LBP_IDX_BR_DUTY:   rd_byte = br_duty_r;
         `LBP_IDX_DR_DUTY:   rd_byte = dr_duty_r;
         `LBP_IDX_DR_RAMP:   rd_byte = {2'b00, dr_ramp_r[5:0]};
         `LBP_IDX_STATUS: begin
            for (int i = 0; i < NCH; i++)
               rd_byte[i] = (st_r[i] != LBP_IDLE);
         end
         default: hit = 1'b0;
      endcase
   end

   assign pslverr = psel & penable & ~hit;

   // captured in the setup cycle: read data comes from a flop, still no wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && !penable)
         prdata <= {24'h000000, rd_byte};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         br_period_r <= `LBP_RST_BR_PERIOD; // [R3]
         config_r    <= `LBP_RST_CONFIG; // [R9]
         p1_duty_r   <= `LBP_RST_P1_DUTY;
         p2_duty_r   <= `LBP_RST_P2_DUTY;
         br_duty_r   <= `LBP_RST_BR_DUTY;
         dr_duty_r   <= `LBP_RST_DR_DUTY;
         dr_ramp_r   <= `LBP_RST_DR_RAMP; // [R18]
      end else if (psel && penable && pwrite) begin
         unique case (paddr[9:2])
            `LBP_IDX_BR_PERIOD: br_period_r <= {1'b0, pwdata[6:0]};
            `LBP_IDX_CONFIG:    config_r    <= {1'b0, pwdata[6:0]};
            `LBP_IDX_P1_DUTY:   p1_duty_r   <= pwdata[7:0]; // [R10]
            `LBP_IDX_P2_DUTY:   p2_duty_r   <= pwdata[7:0]; // [R10]
            `LBP_IDX_BR_DUTY:   br_duty_r   <= pwdata[7:0]; // [R10]
            `LBP_IDX_DR_DUTY:   dr_duty_r   <= pwdata[7:0]; // [R10]
            `LBP_IDX_DR_RAMP:   dr_ramp_r   <= {2'b00, pwdata[5:0]};
            default: ;
         endcase
      end
   end

   // millisecond timebase shared by every channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tb_r <= 14'h0000;
      else if (tick)
         tb_r <= 14'h0000;
      else
         tb_r <= tb_r + 14'h0001;
   end
   assign tick = (tb_r == 14'(MS_CYCLES - 1)); // [R21]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pwm_cnt_r <= 7'h00;
      else if (pwm_cnt_r == 7'(`LBP_PWM_STEPS - 1))
         pwm_cnt_r <= 7'h00;
      else
         pwm_cnt_r <= pwm_cnt_r + 7'h01;
   end

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         logic        act;
         logic        start;
         logic        dir;
         logic [6:0]  lo;
         logic [6:0]  hi;
         logic [6:0]  tgt;
         logic [6:0]  span;
         logic [11:0] len;
         logic [12:0] sum;
         logic        fin;
         act   = chan_req[i].actuate;
         start = act & ~act_d_r[i];
         dir   = (m_r[i] == LBP_DIRECT);
         lo    = dir ? floor_pct(dr_duty_r[`LBP_FLOOR_MSB:`LBP_FLOOR_LSB]) : lo_r[i]; // [R12] [R13]
         hi    = dir ? top_pct(dr_duty_r[`LBP_TOP_MSB:`LBP_TOP_LSB]) : hi_r[i]; // [R12] [R13]
         tgt   = (st_r[i] == LBP_RISE || st_r[i] == LBP_TOP) ? hi : lo; // [R11]
         span  = (hi > lo) ? hi - lo : lo - hi;
         if (!dir)
            len = half_r[i]; // [R19]
         else if (st_r[i] == LBP_RISE)
            len = ramp_ms(dr_ramp_r[`LBP_RISE_MSB:`LBP_RISE_LSB]); // [R16]
         else
            len = ramp_ms(dr_ramp_r[`LBP_FALL_MSB:`LBP_FALL_LSB]); // [R17]
         st_nxt[i]   = st_r[i];
         m_nxt[i]    = m_r[i];
         lvl_nxt[i]  = lvl_r[i];
         lo_nxt[i]   = lo_r[i];
         hi_nxt[i]   = hi_r[i];
         half_nxt[i] = half_r[i];
         ms_nxt[i]   = ms_r[i];
         acc_nxt[i]  = acc_r[i];
         cnt_nxt[i]  = cnt_r[i];
         host_nxt[i] = host_r[i];
         stop_nxt[i] = stop_r[i] | ~act;
         done[i]     = 1'b0;
         fin         = 1'b0;
         sum         = 13'h0000;
         // one step of at most 1 % per ms; a ramp too short for its span
         // simply runs longer, which sets the shortest reachable period
         if (st_r[i] == LBP_RISE || st_r[i] == LBP_FALL) begin
            if (len == 12'h000) begin
               lvl_nxt[i] = tgt;
               fin = 1'b1;
            end else if (tick) begin
               sum = acc_r[i] + 13'(span);
               if (ms_r[i] != 12'hFFF)
                  ms_nxt[i] = ms_r[i] + 12'h001;
               if (sum >= 13'(len) && lvl_r[i] != tgt) begin
                  lvl_nxt[i] = (lvl_r[i] < tgt) ? lvl_r[i] + 7'h01 : lvl_r[i] - 7'h01; // [R4]
                  acc_nxt[i] = (sum - 13'(len) > 13'(len)) ? 13'(len) : sum - 13'(len);
               end else begin
                  acc_nxt[i] = sum;
               end
               fin = (lvl_nxt[i] == tgt) && (ms_nxt[i] >= len); // [R4]
            end
         end
         unique case (st_r[i])
            LBP_IDLE: begin
               lvl_nxt[i] = lo;
               if (start) begin
                  m_nxt[i]    = chan_req[i].led_behavior_select;
                  host_nxt[i] = chan_req[i].by_host;
                  stop_nxt[i] = 1'b0;
                  st_nxt[i]   = LBP_RISE;
                  ms_nxt[i]   = 12'h000;
                  acc_nxt[i]  = 13'h0000;
                  unique case (chan_req[i].led_behavior_select)
                     LBP_PULSE1: begin
                        lo_nxt[i]   = floor_pct(p1_duty_r[3:0]);
                        hi_nxt[i]   = top_pct(p1_duty_r[7:4]);
                        half_nxt[i] = half_ms(pulse1_period);
                        cnt_nxt[i]  = config_r[`LBP_CNT1_MSB:`LBP_CNT1_LSB]; // [R8]
                     end
                     LBP_PULSE2: begin
                        lo_nxt[i]   = floor_pct(p2_duty_r[3:0]);
                        hi_nxt[i]   = top_pct(p2_duty_r[7:4]);
                        half_nxt[i] = half_ms(pulse2_period);
                        cnt_nxt[i]  = config_r[`LBP_CNT2_MSB:`LBP_CNT2_LSB]; // [R7]
                     end
                     LBP_BREATHE: begin
                        lo_nxt[i]   = floor_pct(br_duty_r[3:0]); // [R13]
                        hi_nxt[i]   = top_pct(br_duty_r[7:4]); // [R14]
                        half_nxt[i] = half_ms(br_period_r[6:0]); // [R19]
                     end
                     LBP_DIRECT: ;
                  endcase
               end
            end
            LBP_RISE: begin
               if (dir && !act) begin
                  st_nxt[i] = LBP_FALL;
                  ms_nxt[i] = 12'h000;
                  acc_nxt[i] = 13'h0000;
               end else if (m_r[i] == LBP_BREATHE && !act) begin
                  st_nxt[i] = LBP_IDLE;
                  done[i]   = 1'b1;
               end else if (fin) begin
                  st_nxt[i]  = dir ? LBP_TOP : LBP_FALL; // [R11]
                  ms_nxt[i]  = 12'h000;
                  acc_nxt[i] = 13'h0000;
               end
            end
            LBP_TOP: begin
               lvl_nxt[i] = hi; // [R12]
               if (!act) begin
                  st_nxt[i]  = LBP_FALL;
                  ms_nxt[i]  = 12'h000;
                  acc_nxt[i] = 13'h0000;
               end
            end
            LBP_FALL: begin
               if (dir && start) begin
                  st_nxt[i]  = LBP_RISE;
                  ms_nxt[i]  = 12'h000;
                  acc_nxt[i] = 13'h0000;
               end else if (m_r[i] == LBP_BREATHE && !act) begin
                  st_nxt[i] = LBP_IDLE;
                  done[i]   = 1'b1;
               end else if (fin) begin
                  ms_nxt[i]  = 12'h000;
                  acc_nxt[i] = 13'h0000;
                  st_nxt[i]  = LBP_RISE;
                  unique case (m_r[i])
                     LBP_DIRECT: begin
                        st_nxt[i] = LBP_IDLE;
                        done[i]   = 1'b1;
                     end
                     LBP_BREATHE: ;
                     LBP_PULSE1: begin
                        if (cnt_r[i] == 3'h0) begin // [R9]
                           st_nxt[i] = LBP_IDLE;
                           done[i]   = 1'b1;
                        end else
                           cnt_nxt[i] = cnt_r[i] - 3'h1;
                     end
                     LBP_PULSE2: begin
                        if (stop_nxt[i]) begin // [R20]
                           if (cnt_r[i] == 3'h0) begin // [R9]
                              st_nxt[i] = LBP_IDLE;
                              done[i]   = 1'b1;
                           end else
                              cnt_nxt[i] = cnt_r[i] - 3'h1;
                        end
                     end
                  endcase
               end
            end
         endcase
         done_host[i] = done[i] & host_r[i]; // [R6]
      end
   end

   // each channel owns its own ramp state and counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NCH; i++) begin
            st_r[i]    <= LBP_IDLE;
            m_r[i]     <= LBP_DIRECT;
            lvl_r[i]   <= 7'h00;
            lo_r[i]    <= 7'h00;
            hi_r[i]    <= 7'h00;
            half_r[i]  <= 12'h000;
            ms_r[i]    <= 12'h000;
            acc_r[i]   <= 13'h0000;
            cnt_r[i]   <= 3'h0;
            act_d_r[i] <= 1'b0;
            host_r[i]  <= 1'b0;
            stop_r[i]  <= 1'b0;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            st_r[i]    <= st_nxt[i]; // [R22]
            m_r[i]     <= m_nxt[i];
            lvl_r[i]   <= lvl_nxt[i];
            lo_r[i]    <= lo_nxt[i];
            hi_r[i]    <= hi_nxt[i];
            half_r[i]  <= half_nxt[i];
            ms_r[i]    <= ms_nxt[i];
            acc_r[i]   <= acc_nxt[i];
            cnt_r[i]   <= cnt_nxt[i];
            act_d_r[i] <= chan_req[i].actuate;
            host_r[i]  <= host_nxt[i];
            stop_r[i]  <= stop_nxt[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         led_pwm <= '0;
         alert_n <= 1'b1;
      end else begin
         for (int i = 0; i < NCH; i++)
            led_pwm[i] <= (pwm_cnt_r < lvl_r[i]);
         // only host-started work may alert; touch-started never does
         alert_n <= ~(config_r[`LBP_RAMP_ALERT_BIT] & (|done_host)); // [R5] [R6]
      end
   end

endmodule : lbp_led_engine

// *** lbp_led_engine_chk.sv ***
/*
 checker for the apb answers and the alert pulse of lbp_led_engine.
 assumes it is bound to that module and sees its ports only.
*/
`timescale 1ns/1ps
module lbp_led_engine_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [9:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        alert_n
);
   logic [7:0] per_r;
   logic [7:0] cfg_r;
   logic [7:0] ramp_r;
   logic [7:0] dty_r [4];
   wire        acc = psel && penable;
   wire  [7:0] ix  = paddr[9:2];
   wire        rd  = acc && !pwrite;
   wire        dix = ix >= 8'h90 && ix <= 8'h93;
   wire        hit = ix == 8'h86 || ix == 8'h88 || dix || ix == 8'h94 || ix == 8'h97;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // shadow of the writable registers, so reads are judged against writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_r <= 8'h5D;
         cfg_r <= 8'h04;
         ramp_r <= 8'h00;
         for (int i = 0; i < 4; i++)
            dty_r[i] <= 8'hF0;
      end else if (acc && pwrite && pready) begin
         if (ix == 8'h86)
            per_r <= pwdata[7:0];
         if (ix == 8'h88)
            cfg_r <= pwdata[7:0];
         if (ix == 8'h94)
            ramp_r <= pwdata[7:0];
         if (dix)
            dty_r[ix[1:0]] <= pwdata[7:0];
      end
   end
   AST_UNMAPPED: assert property (acc && !hit |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   AST_MAPPED: assert property (acc && hit |-> pready && !pslverr)
      else $error("mapped access refused");
   AST_PERIOD: assert property (rd && ix == 8'h86 |-> prdata == {25'h0, per_r[6:0]})
      else $error("period readback wrong");
   AST_CONFIG: assert property (rd && ix == 8'h88 |-> prdata == {25'h0, cfg_r[6:0]})
      else $error("config readback wrong");
   AST_DUTY: assert property (rd && dix |-> prdata == {24'h0, dty_r[ix[1:0]]})
      else $error("duty readback wrong");
   AST_RAMP: assert property (rd && ix == 8'h94 |-> prdata == {26'h0, ramp_r[5:0]})
      else $error("ramp readback wrong");
   AST_ALERT_PULSE: assert property ($fell(alert_n) |=> alert_n)
      else $error("alert longer than one cycle");
   AST_ALERT_CFG: assert property ($fell(alert_n) |-> $past(cfg_r[6]))
      else $error("alert while disabled");
endmodule : lbp_led_engine_chk

bind lbp_led_engine lbp_led_engine_chk i_lbp_led_engine_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .alert_n
);

// *** lbp_led_model.sv ***
/*
 behavioural led array: per channel, lit clocks over the last 100 clocks.
 assumes led_pwm high means lit and a 100-clock pwm frame.
*/
`timescale 1ns/1ps
module lbp_led_model (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic [7:0] led_pwm,
   output logic     [6:0] duty [8]
);
   logic [99:0] hist [8];
   // a sliding window equals the level whenever the level holds a frame
   always_ff @(posedge pclk or negedge presetn) begin
      for (int i = 0; i < 8; i++) begin
         if (!presetn) begin
            hist[i] <= '0;
            duty[i] <= '0;
         end else begin
            hist[i] <= {hist[i][98:0], led_pwm[i]};
            duty[i] <= duty[i] + 7'(led_pwm[i]) - 7'(hist[i][99]);
         end
      end
   end
endmodule : lbp_led_model

// *** tb_lbp_led_engine.sv ***
/*
 testbench for lbp_led_engine: registers over apb, direct and breathe
 behaviour of channel 0 measured by the led model, pulse behaviour by alert timing.
 assumes a 10 clock millisecond tick in simulation.
*/
`timescale 1ns/1ps
module tb_lbp_led_engine;
   import lbp_pkg::*;
   logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [9:0]    paddr = '0;
   logic [31:0]   pwdata = '0, prdata, rd;
   logic          pready, pslverr, alert_n, er;
   logic [7:0]    led_pwm;
   logic [6:0]    p1_per = 7'h0A, p2_per = 7'h03;
   lbp_chan_req_t req [8];
   logic [6:0]    duty [8];
   int            mismatches = 0, comparisons = 0, cyc = 0, n;
   const logic [6:0] TOP [16] = '{7'h07, 7'h09, 7'h0B, 7'h0E, 7'h11, 7'h14, 7'h17, 7'h1A,
      7'h1E, 7'h23, 7'h28, 7'h2E, 7'h35, 7'h3F, 7'h4D, 7'h64};
   const logic [7:0] IX [7] = '{8'h86, 8'h88, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94};
   const logic [7:0] MSK [7] = '{8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F};

   lbp_led_engine #(.MS_CYCLES(10)) i_lbp_led_engine (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .chan_req(req), .pulse1_period(p1_per), .pulse2_period(p2_per),
      .led_pwm, .alert_n);
   lbp_led_model i_lbp_led_model (.pclk, .presetn, .led_pwm, .duty);

   initial
      for (int i = 0; i < 8; i++)
         req[i] <= '{LBP_DIRECT, 1'b0, 1'b0};
   always #50 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      // the scenarios take about 50000 clocks
      if (cyc == 60000) begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (mismatches == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {ix, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle limit here: a hung slave is ended by the bench timeout
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [7:0] ix, input logic [7:0] d);
      apb(1'b1, ix, d, rd, er);
   endtask : wr
   task automatic rdc(input logic [7:0] ix, input logic [31:0] exp);
      apb(1'b0, ix, 8'h00, rd, er);
      check(rd, exp);
   endtask : rdc
   task automatic act(input lbp_mode_t m, input logic a, input logic h);
      req[0] <= '{m, a, h};
      @(posedge pclk);
   endtask : act
   // clocks until the alert pulse, or hi when none came
   task automatic alert_wait(input int hi);
      n = 0;
      while (alert_n !== 1'b0 && n < hi) begin
         @(posedge pclk);
         n++;
      end
   endtask : alert_wait

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(8'h86, 32'h5D);
      rdc(8'h88, 32'h04);
      rdc(8'h94, 32'h00);
      for (int i = 0; i < 4; i++)
         rdc(8'h90 + 8'(i), 32'hF0);
      for (int i = 0; i < 7; i++) begin
         wr(IX[i], 8'hFF);
         rdc(IX[i], {24'h0, MSK[i]});
      end
      wr(8'h95, 8'h55);
      apb(1'b0, 8'h95, 8'h00, rd, er);
      check({31'h0, er}, 32'h1);
      check(rd, 32'h0);
      for (int i = 0; i < 4; i++)
         wr(8'h90 + 8'(i), 8'hF0);
      // direct: top follows live writes while actuated, floor after release
      wr(8'h94, 8'h00);
      act(LBP_DIRECT, 1'b1, 1'b1);
      rdc(8'h97, 32'h01);
      for (int i = 0; i < 16; i++) begin
         wr(8'h93, 8'(i << 4));
         repeat (300) @(posedge pclk);
         check(32'(duty[0]), 32'(TOP[i]));
      end
      act(LBP_DIRECT, 1'b0, 1'b1);
      for (int i = 0; i < 16; i++) begin
         wr(8'h93, 8'hF0 | 8'(i));
         repeat (300) @(posedge pclk);
         check(32'(duty[0]), (i == 0) ? 32'h0 : 32'(TOP[i - 1]));
      end
      rdc(8'h97, 32'h00);
      // direct ramps: rise 250 ms, fall 500 ms, sampled half way
      wr(8'h93, 8'hF0);
      repeat (1250) @(posedge pclk);
      wr(8'h94, 8'h0A);
      act(LBP_DIRECT, 1'b1, 1'b1);
      repeat (1250) @(posedge pclk);
      check(32'(duty[0] >= 35 && duty[0] <= 60), 32'h1);
      repeat (1500) @(posedge pclk);
      check(32'(duty[0]), 32'h64);
      act(LBP_DIRECT, 1'b0, 1'b1);
      repeat (2500) @(posedge pclk);
      check(32'(duty[0] >= 40 && duty[0] <= 65), 32'h1);
      repeat (3000) @(posedge pclk);
      // first pulse: two breaths of 320 ms, alert only for host starts
      wr(8'h88, 8'h41);
      act(LBP_PULSE1, 1'b1, 1'b1);
      alert_wait(9000);
      check(32'(n > 6200 && n < 6700), 32'h1);
      act(LBP_PULSE1, 1'b0, 1'b1);
      act(LBP_PULSE1, 1'b1, 1'b0);
      alert_wait(8000);
      check(n, 8000);
      act(LBP_PULSE1, 1'b0, 1'b1);
      wr(8'h88, 8'h01);
      act(LBP_PULSE1, 1'b1, 1'b1);
      alert_wait(8000);
      check(n, 8000);
      act(LBP_PULSE1, 1'b0, 1'b1);
      // second pulse: 96 ms period stretches to 200 ms breaths, two after stop
      wr(8'h88, 8'h48);
      act(LBP_PULSE2, 1'b1, 1'b1);
      act(LBP_PULSE2, 1'b0, 1'b1);
      alert_wait(6000);
      check(32'(n > 3800 && n < 4300), 32'h1);
      // breathe 320 ms: top at half period, floor at full period; a duty
      // write while running must wait for the next actuation
      wr(8'h86, 8'h0A);
      act(LBP_BREATHE, 1'b1, 1'b1);
      wr(8'h92, 8'h00);
      repeat (1650) @(posedge pclk);
      check(32'(duty[0] >= 85), 32'h1);
      repeat (1600) @(posedge pclk);
      check(32'(duty[0] <= 20), 32'h1);
      act(LBP_BREATHE, 1'b0, 1'b1);
      alert_wait(50);
      check(32'(n < 50), 32'h1);
      print_verdict();
   end
endmodule : tb_lbp_led_engine
